// >>> core/fblp_params.svh
// offsets, field positions, reset values and codes for the flash boot lock protection
// assumes a 32-bit classic wishbone slave with byte addressing
`ifndef FBLP_PARAMS_SVH
`define FBLP_PARAMS_SVH
`define FBLP_OFS_LOCK 8'h00
`define FBLP_OFS_CTRL 8'h04
`define FBLP_OFS_BOOT_START 8'h08
`define FBLP_OFS_HALT_START 8'h0C
`define FBLP_OFS_STATUS 8'h10
`define FBLP_LOCK_APP_LO 0
`define FBLP_LOCK_APP_HI 1
`define FBLP_LOCK_BOOT_LO 2
`define FBLP_LOCK_BOOT_HI 3
`define FBLP_LOCK_ERASED 4'hF
`define FBLP_CTRL_VEC_BOOT 0
`define FBLP_STAT_BUSY 0
`define FBLP_STAT_OP 1
`define FBLP_STAT_HALT 2
`define FBLP_BOOT_START_RST 16'h0C00
`define FBLP_HALT_START_RST 16'h0C00
`define FBLP_ADDR_W 16
`endif

// >>> core/fblp_pkg.sv
// types for the flash boot lock protection block
// assumes nothing beyond the params header
`default_nettype none
package fblp_pkg;
	typedef enum logic [2:0] {
		FBLP_CMD_NONE = 3'h0,
		FBLP_CMD_BUF_LOAD = 3'h1,
		FBLP_CMD_ERASE = 3'h2,
		FBLP_CMD_WRITE = 3'h3,
		FBLP_CMD_LOCK_SET = 3'h4,
		FBLP_CMD_CONC_EN = 3'h5,
		FBLP_CMD_LOAD = 3'h6
	} fblp_cmd_t;
	typedef enum logic [1:0] {
		FBLP_ST_IDLE = 2'h0,
		FBLP_ST_CONC_OP = 2'h1,
		FBLP_ST_HALT_OP = 2'h2
	} fblp_state_t;
	typedef struct packed {
		logic valid;
		fblp_cmd_t cmd;
		logic [15:0] addr;
		logic [15:0] pc;
		logic [3:0] lock_data;
	} fblp_req_t;
	typedef struct packed {
		logic done;
		logic denied;
	} fblp_resp_t;
	typedef struct packed {
		logic start;
		logic erase;
		logic write;
		logic buf_load;
		logic [15:0] addr;
	} fblp_flash_cmd_t;
endpackage
`default_nettype wire

// >>> core/fblp_core.sv
// flash boot lock protection: gates cpu program store/load against the lock bits
// assumes cpu requests and flash completion are on clk_i; wishbone classic slave
//
// Contract
// (RL1) page op in concurrent_read_section keeps halting_section readable, cpu runs
// (RL2) page op in halting_section halts cpu, nothing readable until done
// (RL3) app and boot lock pairs are held separately and set independently
// (RL4) locks set by software or programming mode; only chip erase restores ones; here reset_n_i also loads ones
// (RL5) device-wide write lock does not gate self-programming stores
// (RL6) device-wide read/write lock does not restrict cpu loads or stores
// (RL7) lock bit one means unprogrammed, zero means programmed
// (RL8) app pair 11: no restriction on app section
// (RL9) app pair 10: stores to app section blocked
// (RL10) app pair 00: stores blocked, boot-code loads of app blocked, irq masking
// (RL11) app pair 01: only boot-code loads of app blocked, irq masking
// (RL12) boot pair 11: no restriction on boot section
// (RL13) boot pair 10: stores to boot section blocked
// (RL14) boot pair 00: stores blocked, app-code loads of boot blocked, irq masking
// (RL15) boot pair 01: only app-code loads of boot blocked, irq masking
// (RL16) stores from app-section code are ignored
// (RL17) concurrent section op sets busy flag and blocks that section's reads
// (RL18) blocked store or load changes nothing and starts no operation
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`include "fblp_params.svh"
`default_nettype none
module fblp_core (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire fblp_pkg::fblp_req_t cpu_req_i,
	input wire logic flash_done_i,
	input wire logic chip_erase_i,
	input wire logic prog_lock_we_i,
	input wire logic [3:0] prog_lock_i,
	output fblp_pkg::fblp_resp_t cpu_resp_o,
	output fblp_pkg::fblp_flash_cmd_t flash_cmd_o,
	output logic cpu_halt_o,
	output logic read_block_all_o,
	output logic concurrent_section_busy_flag_o,
	output logic irq_mask_o
);
	////////////////////////////////////////////////////////////////////////////
	logic [3:0] lock_reg;
	logic vec_boot_reg;
	logic [15:0] boot_start_reg;
	logic [15:0] halt_start_reg;
	fblp_pkg::fblp_state_t state_reg;
	logic busy_reg;
	logic wb_hit;
	logic app_hi;
	logic app_lo;
	logic boot_hi;
	logic boot_lo;
	logic pc_boot;
	logic tgt_boot;
	logic tgt_halt;
	logic is_page_op;
	logic store_ok;
	logic load_ok;
	logic page_go;
	logic req_denied;
	logic lock_sw_we;

	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// zero bit means programmed
	assign app_hi = lock_reg[`FBLP_LOCK_APP_HI]; // RL7
	assign app_lo = lock_reg[`FBLP_LOCK_APP_LO];
	assign boot_hi = lock_reg[`FBLP_LOCK_BOOT_HI];
	assign boot_lo = lock_reg[`FBLP_LOCK_BOOT_LO];
	assign pc_boot = cpu_req_i.pc >= boot_start_reg;
	assign tgt_boot = cpu_req_i.addr >= boot_start_reg;
	assign tgt_halt = cpu_req_i.addr >= halt_start_reg;
	assign is_page_op = cpu_req_i.cmd == fblp_pkg::FBLP_CMD_ERASE
		|| cpu_req_i.cmd == fblp_pkg::FBLP_CMD_WRITE;
	assign lock_sw_we = wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `FBLP_OFS_LOCK;

	////////////////////////////////////////////////////////////////////////////
	// store permission: no device-wide lock input exists, only the section pairs
	always_comb
	begin
		store_ok = pc_boot; // RL16 RL5
		if (tgt_boot && !boot_lo)
			store_ok = 1'b0; // RL13 RL14
		if (!tgt_boot && !app_lo)
			store_ok = 1'b0; // RL9 RL10
		if (state_reg != fblp_pkg::FBLP_ST_IDLE)
			store_ok = 1'b0;
	end

	// load permission: lock pairs gate cross-section reads only; page operations also block own-section reads
	always_comb
	begin
		load_ok = 1'b1; // RL6 RL8 RL12
		if (pc_boot && !tgt_boot && !app_hi)
			load_ok = 1'b0; // RL10 RL11
		if (!pc_boot && tgt_boot && !boot_hi)
			load_ok = 1'b0; // RL14 RL15
		if (state_reg == fblp_pkg::FBLP_ST_HALT_OP)
			load_ok = 1'b0; // RL2
		if (busy_reg && !tgt_halt)
			load_ok = 1'b0; // RL17
	end

	always_comb
	begin
		page_go = 1'b0;
		req_denied = 1'b0;
		if (cpu_req_i.valid)
		begin
			case (cpu_req_i.cmd)
				fblp_pkg::FBLP_CMD_ERASE,
				fblp_pkg::FBLP_CMD_WRITE:
				begin
					page_go = store_ok;
					req_denied = !store_ok; // RL18
				end
				fblp_pkg::FBLP_CMD_BUF_LOAD,
				fblp_pkg::FBLP_CMD_LOCK_SET,
				fblp_pkg::FBLP_CMD_CONC_EN:
					req_denied = !pc_boot || state_reg != fblp_pkg::FBLP_ST_IDLE; // RL16
				fblp_pkg::FBLP_CMD_LOAD:
					req_denied = !load_ok; // RL18
				default:
					req_denied = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lock pairs: software, programming mode and cpu lock-set only clear bits
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			lock_reg <= `FBLP_LOCK_ERASED;
		else if (chip_erase_i)
			lock_reg <= `FBLP_LOCK_ERASED; // RL4
		else
		begin
			lock_reg <= lock_reg
				& (lock_sw_we ? wb_dat_i[3:0] : 4'hF)
				& (prog_lock_we_i ? prog_lock_i : 4'hF)
				& ((cpu_req_i.valid && !req_denied
					&& cpu_req_i.cmd == fblp_pkg::FBLP_CMD_LOCK_SET)
					? cpu_req_i.lock_data : 4'hF); // RL3 RL4
		end
	end

	// configuration registers
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			vec_boot_reg <= 1'b0;
			boot_start_reg <= `FBLP_BOOT_START_RST;
			halt_start_reg <= `FBLP_HALT_START_RST;
		end
		else if (wb_hit && wb_we_i)
		begin
			if (wb_adr_i == `FBLP_OFS_CTRL && wb_sel_i[0])
				vec_boot_reg <= wb_dat_i[`FBLP_CTRL_VEC_BOOT];
			if (wb_adr_i == `FBLP_OFS_BOOT_START && wb_sel_i[0])
				boot_start_reg[7:0] <= wb_dat_i[7:0];
			if (wb_adr_i == `FBLP_OFS_BOOT_START && wb_sel_i[1])
				boot_start_reg[15:8] <= wb_dat_i[15:8];
			if (wb_adr_i == `FBLP_OFS_HALT_START && wb_sel_i[0])
				halt_start_reg[7:0] <= wb_dat_i[7:0];
			if (wb_adr_i == `FBLP_OFS_HALT_START && wb_sel_i[1])
				halt_start_reg[15:8] <= wb_dat_i[15:8];
		end
	end

	// bus answer: one cycle after the strobe, unmapped reads give zero
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_hit;
			case (wb_adr_i)
				`FBLP_OFS_LOCK: wb_dat_o <= {28'h000_0000, lock_reg};
				`FBLP_OFS_CTRL: wb_dat_o <= {31'h0, vec_boot_reg};
				`FBLP_OFS_BOOT_START: wb_dat_o <= {16'h0000, boot_start_reg};
				`FBLP_OFS_HALT_START: wb_dat_o <= {16'h0000, halt_start_reg};
				`FBLP_OFS_STATUS: wb_dat_o <= {29'h0, cpu_halt_o,
					state_reg != fblp_pkg::FBLP_ST_IDLE, busy_reg};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// page operation sequencing
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state_reg <= fblp_pkg::FBLP_ST_IDLE;
		else
		begin
			case (state_reg)
				fblp_pkg::FBLP_ST_IDLE:
					if (cpu_req_i.valid && page_go)
						state_reg <= tgt_halt ? fblp_pkg::FBLP_ST_HALT_OP
							: fblp_pkg::FBLP_ST_CONC_OP; // RL1 RL2
				fblp_pkg::FBLP_ST_CONC_OP,
				fblp_pkg::FBLP_ST_HALT_OP:
					if (flash_done_i)
						state_reg <= fblp_pkg::FBLP_ST_IDLE;
				default:
					state_reg <= fblp_pkg::FBLP_ST_IDLE;
			endcase
		end
	end

	// busy flag: set by a concurrent-section start, cleared by read enable or
	// buffer load once idle; a start in the clearing cycle wins
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			busy_reg <= 1'b0;
		else if (cpu_req_i.valid && page_go && !tgt_halt)
			busy_reg <= 1'b1; // RL17
		else if (cpu_req_i.valid && !req_denied
			&& (cpu_req_i.cmd == fblp_pkg::FBLP_CMD_CONC_EN
			|| cpu_req_i.cmd == fblp_pkg::FBLP_CMD_BUF_LOAD))
			busy_reg <= 1'b0;
	end

	// cpu-facing outputs
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cpu_resp_o <= '0;
			flash_cmd_o <= '0;
		end
		else
		begin
			cpu_resp_o.done <= cpu_req_i.valid && !req_denied;
			cpu_resp_o.denied <= cpu_req_i.valid && req_denied;
			flash_cmd_o.start <= cpu_req_i.valid && page_go; // RL18
			flash_cmd_o.erase <= cpu_req_i.valid && page_go
				&& cpu_req_i.cmd == fblp_pkg::FBLP_CMD_ERASE;
			flash_cmd_o.write <= cpu_req_i.valid && page_go
				&& cpu_req_i.cmd == fblp_pkg::FBLP_CMD_WRITE;
			flash_cmd_o.buf_load <= cpu_req_i.valid && !req_denied
				&& cpu_req_i.cmd == fblp_pkg::FBLP_CMD_BUF_LOAD;
			flash_cmd_o.addr <= cpu_req_i.addr;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cpu_halt_o <= 1'b0;
			read_block_all_o <= 1'b0;
			concurrent_section_busy_flag_o <= 1'b0;
			irq_mask_o <= 1'b0;
		end
		else
		begin
			cpu_halt_o <= (state_reg == fblp_pkg::FBLP_ST_IDLE && cpu_req_i.valid
				&& page_go && tgt_halt)
				|| (state_reg == fblp_pkg::FBLP_ST_HALT_OP && !flash_done_i); // RL2
			read_block_all_o <= (state_reg == fblp_pkg::FBLP_ST_IDLE && cpu_req_i.valid
				&& page_go && tgt_halt)
				|| (state_reg == fblp_pkg::FBLP_ST_HALT_OP && !flash_done_i); // RL1 RL2
			concurrent_section_busy_flag_o <= (cpu_req_i.valid && page_go && !tgt_halt)
				|| (busy_reg && !(cpu_req_i.valid && !req_denied
				&& (cpu_req_i.cmd == fblp_pkg::FBLP_CMD_CONC_EN
				|| cpu_req_i.cmd == fblp_pkg::FBLP_CMD_BUF_LOAD))); // RL17
			irq_mask_o <= (vec_boot_reg && !pc_boot && !app_hi)
				|| (!vec_boot_reg && pc_boot && !boot_hi); // RL10 RL11 RL14 RL15
		end
	end

	////////////////////////////////////////////////////////////////////////////
	sequence s_halt_start;
		cpu_req_i.valid && page_go && tgt_halt;
	endsequence
	sequence s_conc_start;
		cpu_req_i.valid && page_go && !tgt_halt;
	endsequence

	a_halt_op_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL2
		s_halt_start |=> cpu_halt_o && read_block_all_o)
		else $error("halt missing after halting-section start");
	a_conc_no_halt: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL1
		s_conc_start |=> !cpu_halt_o && concurrent_section_busy_flag_o)
		else $error("concurrent-section op halted cpu or left busy clear");
	a_app_store_block: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL9
		cpu_req_i.valid && is_page_op && !tgt_boot && !app_lo
		|=> !flash_cmd_o.start && cpu_resp_o.denied)
		else $error("store to locked application section started");
	a_boot_store_block: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL13
		cpu_req_i.valid && is_page_op && tgt_boot && !boot_lo
		|=> !flash_cmd_o.start)
		else $error("store to locked boot section started");
	a_app_code_store: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL16
		cpu_req_i.valid && is_page_op && !pc_boot |=> !flash_cmd_o.start)
		else $error("store from application code started");
	a_boot_load_block: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL14
		cpu_req_i.valid && cpu_req_i.cmd == fblp_pkg::FBLP_CMD_LOAD
		&& !pc_boot && tgt_boot && !boot_hi |=> cpu_resp_o.denied)
		else $error("load of locked boot section allowed");
	a_app_load_block: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL10
		cpu_req_i.valid && cpu_req_i.cmd == fblp_pkg::FBLP_CMD_LOAD
		&& pc_boot && !tgt_boot && !app_hi |=> cpu_resp_o.denied)
		else $error("load of locked application section allowed");
	a_lock_only_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL4
		!chip_erase_i |=> (lock_reg & ~$past(lock_reg)) == 4'h0)
		else $error("lock bit returned to one without chip erase");
	a_erase_unlocks: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL4
		chip_erase_i |=> lock_reg == `FBLP_LOCK_ERASED)
		else $error("chip erase left a lock bit programmed");
endmodule // fblp_core
`default_nettype wire

// >>> dv/fblp_flash_model.sv
// flash macro stand-in: answers each page erase or write after a fixed delay
// assumes commands arrive as one-cycle start pulses on clk_i
`default_nettype none
module fblp_flash_model #(
	parameter int DELAY = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire fblp_pkg::fblp_flash_cmd_t flash_cmd_i,
	output logic flash_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int count_reg;
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			count_reg <= 0;
			flash_done_o <= 1'b0;
		end
		else
		begin
			flash_done_o <= (count_reg == 1);
			if (flash_cmd_i.start && (flash_cmd_i.erase || flash_cmd_i.write))
				count_reg <= DELAY;
			else if (count_reg > 0)
				count_reg <= count_reg - 1;
		end
	end
endmodule // fblp_flash_model
`default_nettype wire

// >>> dv/flash_boot_lock_protection_tb.sv
// self-checking bench for the flash boot lock protection core
// assumes the flash model answers page operations after a fixed delay
`include "fblp_params.svh"
`default_nettype none
module flash_boot_lock_protection_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, prog_lock_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic flash_done_i, chip_erase_i, prog_lock_we_i;
	logic cpu_halt_o, read_block_all_o, busy_o, irq_mask_o;
	fblp_pkg::fblp_req_t cpu_req_i;
	fblp_pkg::fblp_resp_t cpu_resp_o;
	fblp_pkg::fblp_flash_cmd_t flash_cmd_o;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	fblp_core DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.cpu_req_i(cpu_req_i), .flash_done_i(flash_done_i), .chip_erase_i(chip_erase_i),
		.prog_lock_we_i(prog_lock_we_i), .prog_lock_i(prog_lock_i),
		.cpu_resp_o(cpu_resp_o), .flash_cmd_o(flash_cmd_o), .cpu_halt_o(cpu_halt_o),
		.read_block_all_o(read_block_all_o), .concurrent_section_busy_flag_o(busy_o),
		.irq_mask_o(irq_mask_o));
	fblp_flash_model #(.DELAY(8)) flash (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.flash_cmd_i(flash_cmd_o), .flash_done_o(flash_done_i));
	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// ack and read data are taken at the rising edge that sees ack high
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// one cpu request, answer judged in the cycle after it is taken
	task automatic trial(input fblp_pkg::fblp_cmd_t c, input logic [15:0] a,
		input logic [15:0] p, input logic den);
		logic st;
		st = !den && (c == fblp_pkg::FBLP_CMD_ERASE || c == fblp_pkg::FBLP_CMD_WRITE);
		@(posedge clk_i);
		cpu_req_i <= '{1'b1, c, a, p, 4'hE};
		@(posedge clk_i);
		cpu_req_i.valid <= 1'b0;
		#1;
		check(cpu_resp_o, {!den, den});
		check(flash_cmd_o, {st, st && c == fblp_pkg::FBLP_CMD_ERASE,
			st && c == fblp_pkg::FBLP_CMD_WRITE,
			!den && c == fblp_pkg::FBLP_CMD_BUF_LOAD, a});
	endtask
	task automatic chip_erase();
		@(posedge clk_i);
		chip_erase_i <= 1'b1;
		@(posedge clk_i);
		chip_erase_i <= 1'b0;
	endtask
	task automatic wait_op();
		for (int i = 0; i < 40 && flash_done_i !== 1'b1; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		check(flash_done_i, 1'b1);
		@(posedge clk_i);
		#1;
	endtask
	task automatic pc_irq(input logic [15:0] p, input logic exp);
		cpu_req_i.pc <= p;
		repeat (2) @(posedge clk_i);
		#1;
		check(irq_mask_o, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset();
		wb(1'b0, `FBLP_OFS_LOCK, 32'h0);
		check(rd, 32'h0000000F);
		wb(1'b0, `FBLP_OFS_STATUS, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, 8'h20, 32'h0);
		check(rd, 32'h0);
	endtask
	task automatic test_prog();
		@(posedge clk_i);
		prog_lock_we_i <= 1'b1;
		prog_lock_i <= 4'h5;
		@(posedge clk_i);
		prog_lock_we_i <= 1'b0;
		wb(1'b1, `FBLP_OFS_LOCK, 32'hF);
		wb(1'b0, `FBLP_OFS_LOCK, 32'h0);
		check(rd, 32'h5);
		trial(fblp_pkg::FBLP_CMD_LOCK_SET, 16'h0, 16'h0C10, 1'b0);
		wb(1'b0, `FBLP_OFS_LOCK, 32'h0);
		check(rd, 32'h4);
		chip_erase();
		wb(1'b0, `FBLP_OFS_LOCK, 32'h0);
		check(rd, 32'hF);
	endtask
	task automatic test_app();
		logic [1:0] m;
		wb(1'b1, `FBLP_OFS_CTRL, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			m = i[1:0];
			chip_erase();
			wb(1'b1, `FBLP_OFS_LOCK, {28'h0, 2'b11, m});
			wb(1'b0, `FBLP_OFS_LOCK, 32'h0);
			check(rd, {28'h0, 2'b11, m});
			pc_irq(16'h0100, !m[1]);
			trial(fblp_pkg::FBLP_CMD_LOAD, 16'h0100, 16'h0C10, !m[1]);
			trial(fblp_pkg::FBLP_CMD_ERASE, 16'h0100, 16'h0C10, !m[0]);
			if (m[0])
			begin
				check(busy_o, 1'b1);
				check(cpu_halt_o, 1'b0);
				trial(fblp_pkg::FBLP_CMD_LOAD, 16'h0D00, 16'h0C10, 1'b0);
				trial(fblp_pkg::FBLP_CMD_LOAD, 16'h0100, 16'h0C10, 1'b1);
				wb(1'b0, `FBLP_OFS_STATUS, 32'h0);
				check(rd, 32'h3);
				wait_op();
				trial(fblp_pkg::FBLP_CMD_CONC_EN, 16'h0, 16'h0C10, 1'b0);
				check(busy_o, 1'b0);
			end
		end
	endtask
	task automatic test_boot();
		logic [1:0] m;
		wb(1'b1, `FBLP_OFS_CTRL, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			m = i[1:0];
			chip_erase();
			wb(1'b1, `FBLP_OFS_LOCK, {28'h0, m, 2'b11});
			pc_irq(16'h0C10, !m[1]);
			trial(fblp_pkg::FBLP_CMD_LOAD, 16'h0D00, 16'h0100, !m[1]);
			trial(fblp_pkg::FBLP_CMD_ERASE, 16'h0D00, 16'h0C10, !m[0]);
			if (m[0])
			begin
				check({cpu_halt_o, read_block_all_o}, 2'b11);
				trial(fblp_pkg::FBLP_CMD_LOAD, 16'h0D00, 16'h0C10, 1'b1);
				wb(1'b0, `FBLP_OFS_STATUS, 32'h0);
				check(rd, 32'h6);
				wait_op();
				check(cpu_halt_o, 1'b0);
			end
		end
	endtask
	task automatic test_app_code();
		chip_erase();
		trial(fblp_pkg::FBLP_CMD_ERASE, 16'h0100, 16'h0100, 1'b1);
		trial(fblp_pkg::FBLP_CMD_BUF_LOAD, 16'h0100, 16'h0100, 1'b1);
		trial(fblp_pkg::FBLP_CMD_WRITE, 16'h0100, 16'h0C10, 1'b0);
		trial(fblp_pkg::FBLP_CMD_BUF_LOAD, 16'h0100, 16'h0C10, 1'b1);
		wait_op();
		trial(fblp_pkg::FBLP_CMD_BUF_LOAD, 16'h0100, 16'h0C10, 1'b0);
		check(busy_o, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			results();
		end
	end
	initial
	begin
		reset_n_i = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hF;
		{chip_erase_i, prog_lock_we_i, prog_lock_i} = '0;
		cpu_req_i = '0;
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		test_reset();
		test_prog();
		test_app();
		test_boot();
		test_app_code();
		results();
	end
endmodule // flash_boot_lock_protection_tb
`default_nettype wire
